// ### octal_ddr_psram_interface.sv
// device-side command, burst and mode register logic of an octal ddr pseudo-sram
`timescale 1ns/1ps
`default_nettype none

module octal_ddr_psram_interface
  import psram_octal_pkg::*;
#(
  parameter int INIT_WAIT_CYCLES = INIT_CYCLES,
  parameter int SLEEP_WAIT = SLEEP_WAIT_CYCLES,
  parameter int PD_WAIT = PD_WAIT_CYCLES,
  // identification bytes: arbitrary neutral values
  parameter logic [7:0] ID_LOW_VALUE = 8'h00,
  parameter logic [7:0] ID_HIGH_VALUE = 8'h10
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic linkClk,
  input wire logic csN,
  input wire logic resetPinN,
  input wire logic [7:0] dqIn,
  output logic [7:0] dqOut,
  output logic dqOe,
  input wire logic strobeMaskIn,
  output logic strobeMaskOut,
  output logic strobeMaskOe,
  output logic [ADDR_W-1:0] memRdAddr,
  input wire logic [7:0] memRdData,
  input wire logic refreshPending,
  output logic [ADDR_W-1:0] memWrAddr,
  output logic [7:0] memWrData,
  output logic memWrEn,
  output logic deviceReady,
  output logic sleepEntry,
  output logic powerdownEntry,
  output logic [1:0] driveStrength
);

  // =====================================================================
  // state
  typedef enum logic [2:0] {
    PH_INIT, PH_IDLE, PH_CMD, PH_ADDR, PH_LAT, PH_DATA, PH_DROP
  } phase_e;

  typedef struct packed {
    phase_e phase;
    logic [15:0] initCnt;
    logic [15:0] upCnt;
    logic linkPrev;
    logic [7:0] opcode;
    logic [1:0] addrIdx;
    logic [2:0] riseCnt;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
    logic [4:0] latCnt;
    logic [4:0] latTarget;
    logic [9:0] byteCnt;
    logic hybPhase;
    logic [7:0] latDrive;
    logic [7:0] wrLat;
    logic [7:0] burstCfg;
    logic sleepReq;
    logic pdReq;
    logic [7:0] dqOut;
    logic dqOe;
    logic smOut;
    logic smOe;
    logic [ADDR_W-1:0] wrAddr;
    logic [7:0] wrData;
    logic wrEn;
    logic sleepPulse;
    logic pdPulse;
  } state_s;

  state_s r;
  state_s n;

  // =====================================================================
  // pin synchronisers
  logic [11:0] syncQ;

  // resetPinN should be tied high on the board if unused
  sync_2ff #(
    .W(12),
    .RESET_VALUE(SYNC_RST)
  ) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({csN, linkClk, resetPinN, strobeMaskIn, dqIn}),
    .q(syncQ)
  );

  logic csS;
  logic linkS;
  logic resetS;
  logic maskS;
  logic [7:0] dqS;
  assign csS = syncQ[11];
  assign linkS = syncQ[10];
  assign resetS = syncQ[9];
  assign maskS = syncQ[8];
  assign dqS = syncQ[7:0];

  // =====================================================================
  // decode
  logic rise;
  logic fall;
  logic edgeEv;
  assign rise = linkS & ~r.linkPrev;
  assign fall = ~linkS & r.linkPrev;
  assign edgeEv = rise | fall;

  logic isRead;
  logic isWrite;
  logic isReg;
  logic isLinear;
  assign isRead = (r.opcode == CMD_SYNC_RD) | (r.opcode == CMD_LIN_RD) |
                  (r.opcode == CMD_REG_RD);
  assign isWrite = (r.opcode == CMD_SYNC_WR) | (r.opcode == CMD_LIN_WR) |
                   (r.opcode == CMD_REG_WR);
  assign isReg = (r.opcode == CMD_REG_RD) | (r.opcode == CMD_REG_WR);
  assign isLinear = (r.opcode == CMD_LIN_RD) | (r.opcode == CMD_LIN_WR);

  logic [2:0] rdCode;
  logic [4:0] baseLat;
  logic [4:0] rdLat;
  logic [4:0] startLat;
  assign rdCode = r.latDrive[LAT_CODE_LSB+:3];
  assign baseLat = (rdCode > RD_CODE_MAX) ? LAT_MAX : LAT_BASE + {2'b00, rdCode};
  // fixed latency, or a refresh colliding with an array read, doubles the wait
  assign rdLat = (r.latDrive[LAT_TYPE_BIT] | (refreshPending & ~isReg)) ?
                 {baseLat[3:0], 1'b0} : baseLat;
  assign startLat = !isWrite ? rdLat :
                    isReg ? REG_WR_LAT :
                    wl_decode(r.wrLat[WLAT_LSB+:3]);

  logic [7:0] regRdData;
  always_comb begin
    unique case (r.col[7:0])
      REG_LATENCY_DRIVE: regRdData = r.latDrive;
      REG_ID_LOW: regRdData = ID_LOW_VALUE;
      REG_ID_HIGH: regRdData = ID_HIGH_VALUE;
      REG_CAPS: regRdData = CAPS_VALUE;
      REG_WRITE_LATENCY: regRdData = r.wrLat;
      REG_BURST_CONFIG: regRdData = r.burstCfg;
      default: regRdData = 8'h00;
    endcase
  end

  // =====================================================================
  // burst address stepping
  logic [9:0] mask;
  logic hybrid;
  logic rowCross;
  logic [COL_W-1:0] colInc;
  logic [COL_W-1:0] wrapNext;
  logic [COL_W-1:0] jumpCol;
  assign mask = isLinear ? 10'h3ff : wrap_mask(r.burstCfg[BLEN_LSB+:2]);
  assign hybrid = r.burstCfg[HYB_BIT] & ~isLinear & (mask != 10'h3ff);
  assign rowCross = isLinear & isRead & ~isReg & r.burstCfg[ROWX_BIT] &
                    CAPS_VALUE[ROWX_SUPPORT_BIT];
  assign colInc = r.col + 10'h001;
  assign wrapNext = (r.col & ~mask) | (colInc & mask);
  assign jumpCol = (r.col | mask) + 10'h001;

  // =====================================================================
  // next state
  logic dataEdge;
  assign dataEdge = edgeEv & ((r.phase == PH_DATA) |
                    ((r.phase == PH_LAT) & rise & (r.latCnt == r.latTarget)));

  always_comb begin
    n = r;
    n.linkPrev = linkS;
    n.wrEn = 1'b0;
    n.sleepPulse = 1'b0;
    n.pdPulse = 1'b0;
    if (r.phase != PH_INIT && r.upCnt != 16'hffff) begin
      n.upCnt = r.upCnt + 16'h0001;
    end
    if (r.phase != PH_INIT && r.phase != PH_IDLE && rise && r.riseCnt != 3'h7) begin
      n.riseCnt = r.riseCnt + 3'h1;
    end

    if (r.phase == PH_INIT) begin
      // select and link clock are ignored until self-init is over
      if (r.initCnt == 16'(INIT_WAIT_CYCLES - 1)) begin
        n.phase = PH_IDLE;
      end else begin
        n.initCnt = r.initCnt + 16'h0001;
      end
    end else if (csS) begin
      // standby: frame over, release the bus
      n.phase = PH_IDLE;
      n.dqOe = 1'b0;
      n.smOe = 1'b0;
      n.smOut = 1'b0;
      if (r.phase != PH_IDLE) begin
        if (r.opcode == CMD_GLOBAL_RST && r.riseCnt >= GRST_MIN_RISES) begin
          n.latDrive = LATENCY_DRIVE_RST;
          n.wrLat = WRITE_LATENCY_RST;
          n.burstCfg = BURST_CONFIG_RST;
          n.upCnt = 16'h0000;
        end
        n.sleepPulse = r.sleepReq & (r.upCnt >= 16'(SLEEP_WAIT));
        n.pdPulse = r.pdReq & (r.upCnt >= 16'(PD_WAIT));
        n.sleepReq = 1'b0;
        n.pdReq = 1'b0;
      end
    end else begin
      unique case (r.phase)
        PH_IDLE: begin
          n.phase = PH_CMD;
          n.riseCnt = 3'h0;
          n.opcode = 8'h00;
        end
        PH_CMD: begin
          if (rise) begin
            n.opcode = dqS;
            n.phase = PH_ADDR;
            n.addrIdx = 2'h0;
          end
        end
        PH_ADDR: begin
          // skip only the fall after the instruction rise
          if (edgeEv && !(fall && r.riseCnt == 3'h1)) begin
            n.addrIdx = r.addrIdx + 2'h1;
            unique case (r.addrIdx)
              2'h1: n.row[12:6] = dqS[6:0];
              2'h2: begin
                n.row[5:0] = dqS[7:2];
                n.col[9:8] = dqS[1:0];
              end
              2'h3: begin
                n.col[7:0] = dqS;
                n.latCnt = 5'h00;
                n.latTarget = startLat;
                n.byteCnt = 10'h000;
                n.hybPhase = hybrid;
                n.phase = (isRead | isWrite) ? PH_LAT : PH_DROP;
              end
              default: ;
            endcase
          end
        end
        PH_LAT: begin
          if (rise && r.latCnt != r.latTarget) begin
            n.latCnt = r.latCnt + 5'h01;
          end
          if (rise && isRead) begin
            // read preamble: strobe held low until data starts
            n.smOe = 1'b1;
            n.smOut = 1'b0;
          end
          if (dataEdge) begin
            n.phase = PH_DATA;
          end
        end
        PH_DATA: ;
        PH_DROP: ;
        default: n.phase = PH_DROP;
      endcase

      if (dataEdge) begin
        if (r.byteCnt != 10'h3ff) begin
          n.byteCnt = r.byteCnt + 10'h001;
        end
        if (isRead) begin
          n.dqOut = isReg ? regRdData : memRdData;
          n.dqOe = 1'b1;
          n.smOe = 1'b1;
          n.smOut = rise;
        end else if (!maskS) begin
          if (isReg) begin
            if (r.byteCnt == 10'h000) begin
              unique case (r.col[7:0])
                REG_LATENCY_DRIVE: n.latDrive = dqS & LATENCY_DRIVE_WMASK;
                REG_WRITE_LATENCY: n.wrLat = dqS & WRITE_LATENCY_WMASK;
                REG_BURST_CONFIG: n.burstCfg = dqS & BURST_CONFIG_WMASK;
                REG_LOW_POWER: begin
                  n.sleepReq = (dqS == LP_SLEEP_CODE);
                  n.pdReq = (dqS == LP_PD_CODE);
                end
                default: ;
              endcase
            end
          end else begin
            // masked bytes never reach the array
            n.wrEn = 1'b1;
            n.wrAddr = {r.row, r.col};
            n.wrData = dqS;
          end
        end
        if (!isReg) begin
          if (r.hybPhase) begin
            if (r.byteCnt == mask) begin
              n.col = jumpCol;
              n.hybPhase = 1'b0;
            end else begin
              n.col = wrapNext;
            end
          end else if (hybrid) begin
            n.col = colInc;
          end else begin
            n.col = wrapNext;
            if (rowCross && r.col == 10'h3ff) begin
              n.row = r.row + 13'h0001;
            end
          end
        end
      end
    end

    if (!resetS && r.phase != PH_INIT) begin
      // reset pin: registers back to power-up values, frame abandoned
      n.latDrive = LATENCY_DRIVE_RST;
      n.wrLat = WRITE_LATENCY_RST;
      n.burstCfg = BURST_CONFIG_RST;
      n.phase = PH_IDLE;
      n.dqOe = 1'b0;
      n.smOe = 1'b0;
      n.smOut = 1'b0;
      n.sleepReq = 1'b0;
      n.pdReq = 1'b0;
      n.sleepPulse = 1'b0;
      n.pdPulse = 1'b0;
      n.wrEn = 1'b0;
      n.upCnt = 16'h0000;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{phase: PH_INIT, latDrive: LATENCY_DRIVE_RST, wrLat: WRITE_LATENCY_RST,
             burstCfg: BURST_CONFIG_RST, default: '0};
    end else begin
      r <= n;
    end
  end

  // =====================================================================
  // outputs
  assign dqOut = r.dqOut;
  assign dqOe = r.dqOe;
  assign strobeMaskOut = r.smOut;
  assign strobeMaskOe = r.smOe;
  assign memRdAddr = {r.row, r.col};
  assign memWrAddr = r.wrAddr;
  assign memWrData = r.wrData;
  assign memWrEn = r.wrEn;
  assign deviceReady = (r.phase != PH_INIT);
  assign sleepEntry = r.sleepPulse;
  assign powerdownEntry = r.pdPulse;
  assign driveStrength = r.latDrive[DRIVE_LSB+:2];

endmodule : octal_ddr_psram_interface

`default_nettype wire

// ### octal_ddr_psram_interface_test.sv
// self-checking bench for the octal ddr pseudo-sram interface
`timescale 1ns/1ps
`default_nettype none

module octal_ddr_psram_interface_test;
  import psram_octal_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic resetPinN = 1'b1;
  logic refreshPending = 1'b0;
  logic linkClk, csN, hostMask, dqOe, strobeMaskOut, strobeMaskOe, memWrEn;
  logic deviceReady, sleepEntry, powerdownEntry;
  logic [7:0] hostDq, dqOut, memWrData;
  logic [ADDR_W-1:0] memRdAddr, memWrAddr;
  logic [1:0] driveStrength;
  wire logic [7:0] busDq = dqOe ? dqOut : hostDq;
  wire logic busStrobe = strobeMaskOe ? strobeMaskOut : hostMask;
  // array byte is column xor row low byte
  wire logic [7:0] memRdData = memRdAddr[7:0] ^ memRdAddr[17:10];
  int fail_count = 0;
  int n_compared = 0;
  int sleepSeen = 0;
  int pdSeen = 0;
  logic [30:0] wq [$];

  always #5 clk = ~clk;

  octal_ddr_psram_interface #(.INIT_WAIT_CYCLES(20), .SLEEP_WAIT(10), .PD_WAIT(300)) dut_u (
    .clk(clk), .rst_n(rst_n), .linkClk(linkClk), .csN(csN), .resetPinN(resetPinN),
    .dqIn(busDq), .dqOut(dqOut), .dqOe(dqOe), .strobeMaskIn(busStrobe),
    .strobeMaskOut(strobeMaskOut), .strobeMaskOe(strobeMaskOe), .memRdAddr(memRdAddr),
    .memRdData(memRdData), .refreshPending(refreshPending), .memWrAddr(memWrAddr),
    .memWrData(memWrData), .memWrEn(memWrEn), .deviceReady(deviceReady),
    .sleepEntry(sleepEntry), .powerdownEntry(powerdownEntry), .driveStrength(driveStrength)
  );

  psram_host_model host_u (
    .linkClk(linkClk), .csN(csN), .hostDq(hostDq), .hostMask(hostMask),
    .busDq(busDq), .busStrobe(busStrobe)
  );

  // sampled mid-cycle, away from the edge that launches the pulses
  always @(negedge clk) begin
    if (memWrEn === 1'b1) wq.push_back({memWrAddr, memWrData});
    if (sleepEntry === 1'b1) sleepSeen++;
    if (powerdownEntry === 1'b1) pdSeen++;
  end

  // ======================================================
  // helpers
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic rd_check(input string what, input int lat, input logic [7:0] e [4], input int n);
    int k;
    k = 0;
    while (k < 31 && host_u.sbBuf[k] !== 1'b1) k++;
    check({what, " latency"}, 2 * lat, k);
    for (int i = 0; i < n; i++) check(what, e[i], host_u.rdBuf[k + i]);
  endtask : rd_check

  function automatic logic [30:0] w(input logic [9:0] c, input logic [7:0] d);
    return {13'h0c3, c, d};
  endfunction : w

  task automatic wr_check(input logic [30:0] e [4], input int n);
    check("write count", n, wq.size());
    for (int i = 0; i < n; i++) check("write byte", e[i], wq[i]);
    wq.delete();
  endtask : wr_check

  task automatic reg_read(input logic [7:0] idx, input int lat, input logic [7:0] v);
    host_u.xfer(CMD_REG_RD, 8'h00, 8'h00, idx, 8 + 2 * lat, 0, '{default: 8'h00}, 4'h0);
    rd_check("register", lat, '{v, 8'h00, 8'h00, 8'h00}, 1);
  endtask : reg_read

  task automatic reg_write(input logic [7:0] idx, input logic [7:0] v);
    host_u.xfer(CMD_REG_WR, 8'h00, 8'h00, idx, 12, 8, '{v, ~v, ~v, ~v}, 4'h0);
  endtask : reg_write

  // ======================================================
  // scenarios
  task automatic test_init;
    repeat (10) @(negedge clk);
    check("ready early", 0, deviceReady);
    repeat (20) @(negedge clk);
    check("ready", 1, deviceReady);
  endtask : test_init

  task automatic test_regs;
    reg_read(REG_LATENCY_DRIVE, 5, 8'h09);
    reg_read(REG_WRITE_LATENCY, 5, 8'h40);
    reg_read(REG_BURST_CONFIG, 5, 8'h05);
    reg_read(REG_CAPS, 5, 8'h80);
    reg_write(REG_LATENCY_DRIVE, 8'h01);
    reg_read(REG_LATENCY_DRIVE, 3, 8'h01);
    reg_write(REG_CAPS, 8'h00);
    reg_read(REG_CAPS, 3, 8'h80);
    reg_write(REG_LATENCY_DRIVE, 8'h22);
    reg_read(REG_LATENCY_DRIVE, 6, 8'h22);
  endtask : test_regs

  task automatic test_reset;
    @(negedge clk);
    resetPinN = 1'b0;
    repeat (6) @(negedge clk);
    check("drive", 2'b01, driveStrength);
    resetPinN = 1'b1;
    repeat (6) @(negedge clk);
    reg_read(REG_LATENCY_DRIVE, 5, 8'h09);
  endtask : test_reset

  task automatic test_write;
    host_u.xfer(CMD_SYNC_WR, 8'h03, 8'h0c, 8'h08, 20, 16, '{8'h11, 8'h22, 8'h33, 8'h44}, 4'b0010);
    wr_check('{w(10'h008, 8'h11), w(10'h00a, 8'h33), w(10'h00b, 8'h44), 31'h0}, 3);
    reg_write(REG_BURST_CONFIG, 8'h0d);
    host_u.xfer(CMD_LIN_WR, 8'h03, 8'h0f, 8'hfe, 20, 16, '{8'h55, 8'h66, 8'h77, 8'h88}, 4'h0);
    wr_check('{w(10'h3fe, 8'h55), w(10'h3ff, 8'h66), w(10'h000, 8'h77), w(10'h001, 8'h88)}, 4);
  endtask : test_write

  task automatic test_read;
    host_u.xfer(CMD_SYNC_RD, 8'h03, 8'h0c, 8'h1e, 20, 0, '{default: 8'h00}, 4'h0);
    rd_check("hybrid", 5, '{8'hdd, 8'hdc, 8'hc3, 8'hc2}, 4);
    host_u.xfer(CMD_LIN_RD, 8'h03, 8'h0f, 8'hfe, 20, 0, '{default: 8'h00}, 4'h0);
    rd_check("row cross", 5, '{8'h3d, 8'h3c, 8'hc4, 8'hc5}, 4);
    reg_write(REG_BURST_CONFIG, 8'h05);
    host_u.xfer(CMD_LIN_RD, 8'h03, 8'h0f, 8'hfe, 20, 0, '{default: 8'h00}, 4'h0);
    rd_check("in row", 5, '{8'h3d, 8'h3c, 8'hc3, 8'hc2}, 4);
    @(negedge clk);
    refreshPending = 1'b1;
    host_u.xfer(CMD_SYNC_RD, 8'h03, 8'h0c, 8'h04, 30, 0, '{default: 8'h00}, 4'h0);
    rd_check("pushout", 10, '{8'hc7, 8'hc6, 8'hc5, 8'hc4}, 4);
    @(negedge clk);
    refreshPending = 1'b0;
  endtask : test_read

  task automatic test_grst;
    reg_write(REG_LATENCY_DRIVE, 8'h0a);
    check("drive set", 2'b10, driveStrength);
    host_u.xfer(CMD_GLOBAL_RST, 8'h00, 8'h00, 8'h00, 8, 0, '{default: 8'h00}, 4'h0);
    check("drive after global", 2'b01, driveStrength);
  endtask : test_grst

  task automatic test_lowpower;
    reg_write(REG_LOW_POWER, LP_SLEEP_CODE);
    check("sleep entry", 1, sleepSeen);
    @(negedge clk);
    resetPinN = 1'b0;
    repeat (4) @(negedge clk);
    resetPinN = 1'b1;
    repeat (20) @(negedge clk);
    reg_write(REG_LOW_POWER, LP_PD_CODE);
    check("powerdown early", 0, pdSeen);
    repeat (300) @(negedge clk);
    reg_write(REG_LOW_POWER, LP_PD_CODE);
    check("powerdown entry", 1, pdSeen);
  endtask : test_lowpower

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  initial begin
    #200us;
    fail_count++;
    stop_test();
  end

  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    test_init();
    test_regs();
    test_reset();
    test_write();
    test_read();
    test_grst();
    test_lowpower();
    stop_test();
  end
endmodule : octal_ddr_psram_interface_test

`default_nettype wire

// ### psram_host_model.sv
// host link model driving select, link clock, bus and byte mask
`timescale 1ns/1ps
`default_nettype none

module psram_host_model (
  output logic linkClk,
  output logic csN,
  output logic [7:0] hostDq,
  output logic hostMask,
  input wire logic [7:0] busDq,
  input wire logic busStrobe
);
  logic [7:0] rdBuf [32];
  logic sbBuf [32];

  initial begin
    linkClk = 1'b0;
    csN = 1'b1;
    hostDq = 8'h00;
    hostMask = 1'b0;
  end

  // ======================================================
  // one frame; data changes midway between link edges
  task automatic xfer(input logic [7:0] opcode, input logic [7:0] b1, input logic [7:0] b2,
      input logic [7:0] b3, input int nEdges, input int wrStart,
      input logic [7:0] wd [4], input logic [3:0] wm);
    logic [7:0] hdr [6];
    hdr = '{opcode, opcode, 8'h00, b1, b2, b3};
    #31;
    csN = 1'b0;
    hostDq = opcode;
    #31;
    for (int e = 0; e < nEdges; e++) begin
      linkClk = ~linkClk;
      #31;
      if (e + 1 < 6) begin
        hostDq = hdr[e + 1];
      end else if (e + 1 >= wrStart && e + 1 < wrStart + 4) begin
        hostDq = wd[e + 1 - wrStart];
        hostMask = wm[e + 1 - wrStart];
      end else begin
        // released lines show a changing pattern
        hostDq = ~hostDq;
        hostMask = ~hostMask;
      end
      #24;
      if (e >= 6 && e < 38) begin
        rdBuf[e - 6] = busDq;
        sbBuf[e - 6] = busStrobe;
      end
      #7.5;
    end
    csN = 1'b1;
    #100;
  endtask : xfer
endmodule : psram_host_model

`default_nettype wire

// ### psram_if_props.sv
// assertion checker for the octal ddr pseudo-sram interface ports
`timescale 1ns/1ps
`default_nettype none

module psram_if_props
  import psram_octal_pkg::*;
#(
  parameter int INIT_WAIT_CYCLES = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic csN,
  input wire logic resetPinN,
  input wire logic dqOe,
  input wire logic strobeMaskOut,
  input wire logic strobeMaskOe,
  input wire logic memWrEn,
  input wire logic deviceReady,
  input wire logic sleepEntry,
  input wire logic powerdownEntry,
  input wire logic [1:0] driveStrength
);
  // ======================================================
  // cycles since reset release
  logic [15:0] upCnt;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      upCnt <= '0;
    end else if (upCnt != 16'hffff) begin
      upCnt <= upCnt + 16'h0001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ======================================================
  // properties
  a_ready_not_early: assert property (
      deviceReady |-> upCnt >= INIT_WAIT_CYCLES) else $error("ready before init wait");
  a_ready_in_time: assert property (
      upCnt == INIT_WAIT_CYCLES + 8 |-> deviceReady) else $error("ready late");
  a_ready_holds: assert property (
      !$fell(deviceReady)) else $error("ready dropped");
  a_quiet_before_ready: assert property (
      !deviceReady |-> !dqOe && !strobeMaskOe && !memWrEn) else $error("active before ready");
  a_standby_released: assert property (
      csN [*8] |-> !dqOe && !strobeMaskOe && !memWrEn) else $error("active in standby");
  a_preamble_low: assert property (
      $rose(strobeMaskOe) |-> !strobeMaskOut && !dqOe) else $error("strobe not low first");
  a_first_data_strobe: assert property (
      $rose(dqOe) |-> strobeMaskOut && strobeMaskOe) else $error("data without strobe rise");
  a_write_one_pulse: assert property (
      memWrEn |=> !memWrEn [*3]) else $error("write pulse too long");
  a_lp_frame_end: assert property (
      sleepEntry || powerdownEntry |-> csN && !(sleepEntry && powerdownEntry)
      ##1 !sleepEntry && !powerdownEntry) else $error("low power pulse bad");
  a_pin_reset_drive: assert property (
      (deviceReady && !resetPinN) [*6] |-> driveStrength == 2'b01) else $error("pin reset");

  c_write: cover property (memWrEn);
  c_read: cover property ($rose(dqOe));
  c_sleep: cover property (sleepEntry);
  c_powerdown: cover property (powerdownEntry);
endmodule : psram_if_props

bind octal_ddr_psram_interface psram_if_props #(
  .INIT_WAIT_CYCLES(INIT_WAIT_CYCLES)
) props_u (
  .clk(clk),
  .rst_n(rst_n),
  .csN(csN),
  .resetPinN(resetPinN),
  .dqOe(dqOe),
  .strobeMaskOut(strobeMaskOut),
  .strobeMaskOe(strobeMaskOe),
  .memWrEn(memWrEn),
  .deviceReady(deviceReady),
  .sleepEntry(sleepEntry),
  .powerdownEntry(powerdownEntry),
  .driveStrength(driveStrength)
);

`default_nettype wire

// ### psram_octal_pkg.sv
// shared constants for the octal ddr pseudo-sram interface
package psram_octal_pkg;

  // =====================================================================
  // timing
  localparam int CLK_FREQ_MHZ = 100;
  localparam int INIT_TIME_US = 150;
  localparam int INIT_CYCLES = INIT_TIME_US * CLK_FREQ_MHZ;
  localparam int SLEEP_WAIT_CYCLES = 1000;
  localparam int PD_WAIT_CYCLES = 1000;

  // =====================================================================
  // instruction codes
  localparam logic [7:0] CMD_SYNC_RD = 8'h00;
  localparam logic [7:0] CMD_SYNC_WR = 8'h80;
  localparam logic [7:0] CMD_LIN_RD = 8'h20;
  localparam logic [7:0] CMD_LIN_WR = 8'ha0;
  localparam logic [7:0] CMD_REG_RD = 8'h40;
  localparam logic [7:0] CMD_REG_WR = 8'hc0;
  localparam logic [7:0] CMD_GLOBAL_RST = 8'hff;
  localparam logic [2:0] GRST_MIN_RISES = 3'h4;

  // =====================================================================
  // mode register indices, reset values and writable bits
  localparam logic [7:0] REG_LATENCY_DRIVE = 8'h00;
  localparam logic [7:0] REG_ID_LOW = 8'h01;
  localparam logic [7:0] REG_ID_HIGH = 8'h02;
  localparam logic [7:0] REG_CAPS = 8'h03;
  localparam logic [7:0] REG_WRITE_LATENCY = 8'h04;
  localparam logic [7:0] REG_LOW_POWER = 8'h06;
  localparam logic [7:0] REG_BURST_CONFIG = 8'h08;
  localparam logic [7:0] LATENCY_DRIVE_RST = 8'h09;
  localparam logic [7:0] WRITE_LATENCY_RST = 8'h40;
  localparam logic [7:0] BURST_CONFIG_RST = 8'h05;
  localparam logic [7:0] LATENCY_DRIVE_WMASK = 8'h3f;
  localparam logic [7:0] WRITE_LATENCY_WMASK = 8'hef;
  localparam logic [7:0] BURST_CONFIG_WMASK = 8'h0f;
  localparam logic [7:0] CAPS_VALUE = 8'h80;
  localparam logic [7:0] LP_SLEEP_CODE = 8'hf0;
  localparam logic [7:0] LP_PD_CODE = 8'hc0;

  // =====================================================================
  // field positions
  localparam int LAT_TYPE_BIT = 5;
  localparam int LAT_CODE_LSB = 2;
  localparam int DRIVE_LSB = 0;
  localparam int WLAT_LSB = 5;
  localparam int ROWX_BIT = 3;
  localparam int HYB_BIT = 2;
  localparam int BLEN_LSB = 0;
  localparam int ROWX_SUPPORT_BIT = 7;

  // =====================================================================
  // latencies and address layout
  localparam logic [4:0] LAT_BASE = 5'h03;
  localparam logic [2:0] RD_CODE_MAX = 3'h4;
  localparam logic [4:0] LAT_MAX = 5'h07;
  localparam logic [4:0] REG_WR_LAT = 5'h01;
  localparam int ROW_W = 13;
  localparam int COL_W = 10;
  localparam int ADDR_W = ROW_W + COL_W;
  localparam logic [11:0] SYNC_RST = 12'ha00;

  function automatic logic [4:0] wl_decode(input logic [2:0] code);
    unique case (code)
      3'b000: wl_decode = 5'h03;
      3'b100: wl_decode = 5'h04;
      3'b010: wl_decode = 5'h05;
      3'b110: wl_decode = 5'h06;
      default: wl_decode = LAT_MAX;
    endcase
  endfunction : wl_decode

  function automatic logic [9:0] wrap_mask(input logic [1:0] code);
    unique case (code)
      2'b00: wrap_mask = 10'h00f;
      2'b01: wrap_mask = 10'h01f;
      2'b10: wrap_mask = 10'h03f;
      default: wrap_mask = 10'h3ff;
    endcase
  endfunction : wrap_mask

endpackage : psram_octal_pkg

// ### sync_2ff.sv
// two flip-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
`default_nettype none

module sync_2ff #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VALUE = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= RESET_VALUE;
      q <= RESET_VALUE;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : sync_2ff

`default_nettype wire
